// file: tmc_pkg.sv
package tmc_pkg;
  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int REG_COUNT = 8;
  localparam int REG_WIDTH = 13;
  localparam int ADDR_WIDTH = 3;
  localparam logic [2:0] ADDR_MAIN = 3'h0;
  localparam logic [2:0] ADDR_GEN_TWO = 3'h2;
  localparam logic [2:0] ADDR_GEN_THREE = 3'h3;
  localparam logic [2:0] ADDR_GEN_FIVE = 3'h5;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int MAIN_PD_BIT = 12;
  localparam int MAIN_DIR_BIT = 11;
  localparam int MAIN_SEL_LO = 8;
  localparam int MAIN_GAIN_LO = 6;
  localparam int MAIN_LNA_LO = 4;
  localparam int MAIN_MIX_LO = 2;
  localparam int MAIN_OSC_LO = 0;
  localparam int GEN_TWO_GAIN4_BIT = 8;
  localparam int GEN_THREE_GAIN_LO = 11;
  localparam int GEN_FIVE_TDEM_HI_BIT = 8;
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [12:0] MAIN_RESET = 13'h002a;
  localparam logic [12:0] GEN_TWO_RESET = 13'h0040;
  localparam logic [12:0] GEN_RESET = 13'h0000;
  localparam logic [103:0] RESET_FLAT = {GEN_RESET, GEN_RESET, GEN_RESET, GEN_RESET,
    GEN_RESET, GEN_TWO_RESET, GEN_RESET, MAIN_RESET};
  localparam logic [1:0] BIAS_NOMINAL = 2'h2;
  // ****************************************************************
  // synthesiser test selector and lock pin sources
  // ****************************************************************
  typedef enum logic [2:0] {
    SEL_NORMAL = 3'b000,
    SEL_VCO_NOMOD = 3'b001,
    SEL_VCO_MOD = 3'b010,
    SEL_REF_DIV = 3'b011,
    SEL_TXDATA_MOD = 3'b100,
    SEL_PRESCALER = 3'b101,
    SEL_PRESC_NOMOD = 3'b110,
    SEL_SHIFT_DATA = 3'b111
  } tmc_synth_sel_e;
  localparam int PIN_COUNT = 8;
  localparam logic [2:0] PIN_PLL_LOCK = 3'h0;
  localparam logic [2:0] PIN_VCO_DIV = 3'h1;
  localparam logic [2:0] PIN_REF_DIV = 3'h2;
  localparam logic [2:0] PIN_PRESCALER = 3'h3;
  localparam logic [2:0] PIN_SHIFT_DATA = 3'h4;
  localparam logic [2:0] PIN_DEMOD_TEST = 3'h5;
  localparam logic [2:0] PIN_TX_DATA = 3'h6;
  localparam logic [2:0] PIN_DUAL_MOD = 3'h7;

  // which synchronised source the lock pin shows
  function automatic logic [2:0] tmc_lock_source(input logic [2:0] sel, input logic demodHi);
    logic [2:0] src;
    src = PIN_PLL_LOCK;
    if (demodHi) begin
      src = PIN_DEMOD_TEST;
    end else begin
      case (sel)
        SEL_VCO_NOMOD, SEL_VCO_MOD, SEL_TXDATA_MOD: src = PIN_VCO_DIV;
        SEL_REF_DIV: src = PIN_REF_DIV;
        SEL_PRESCALER, SEL_PRESC_NOMOD: src = PIN_PRESCALER;
        SEL_SHIFT_DATA: src = PIN_SHIFT_DATA;
        default: src = PIN_PLL_LOCK;
      endcase
    end
    return src;
  endfunction : tmc_lock_source
endpackage : tmc_pkg

// file: tmc_reg_store.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_reg_store #(
  parameter int REG_COUNT = 8,
  parameter int REG_WIDTH = 13,
  parameter int ADDR_WIDTH = 3,
  parameter logic [REG_COUNT*REG_WIDTH-1:0] RESET_FLAT = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // write side
  input wire logic wrEn,
  input wire logic [ADDR_WIDTH-1:0] wrAddr,
  input wire logic [REG_WIDTH-1:0] wrData,
  // read side
  input wire logic rdEn,
  input wire logic [ADDR_WIDTH-1:0] rdAddr,
  output logic [REG_WIDTH-1:0] rdData,
  // all words for static decoding
  output logic [REG_COUNT*REG_WIDTH-1:0] wordsFlat
);
  // ****************************************************************
  // storage words
  // ****************************************************************
  for (genvar i = 0; i < REG_COUNT; i++) begin : gWord
    wire logic hit = wrEn && (wrAddr == ADDR_WIDTH'(i));
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        wordsFlat[i*REG_WIDTH +: REG_WIDTH] <= RESET_FLAT[i*REG_WIDTH +: REG_WIDTH];
      end else if (hit) begin
        wordsFlat[i*REG_WIDTH +: REG_WIDTH] <= wrData;
      end
    end
  end

  // ****************************************************************
  // registered read, zero outside the answer cycle
  // ****************************************************************
  wire logic [REG_WIDTH-1:0] readWord = wordsFlat[rdAddr*REG_WIDTH +: REG_WIDTH];
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= '0;
    end else begin
      rdData <= rdEn ? readWord : '0;
    end
  end
endmodule : tmc_reg_store
`default_nettype wire

// file: tmc_lock_mux.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_lock_mux (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // selection
  input wire logic [2:0] synthSel,
  input wire logic demodHi,
  input wire logic [tmc_pkg::PIN_COUNT-1:0] pinSync,
  // results
  output logic lockPin,
  output logic modCtrlEnable,
  output logic modFromTxData,
  output logic modCtrl
);
  import tmc_pkg::*;
  // ****************************************************************
  // selection
  // ****************************************************************
  wire logic [2:0] srcIdx = tmc_lock_source(synthSel, demodHi);
  wire logic next_lockPin = pinSync[srcIdx];
  // modulation held off only by the two test codes that say so
  wire logic next_modCtrlEnable = demodHi ||
    !((synthSel == SEL_VCO_NOMOD) || (synthSel == SEL_PRESC_NOMOD));
  wire logic next_modFromTxData = !demodHi && (synthSel == SEL_TXDATA_MOD);
  wire logic next_modCtrl = next_modFromTxData ? pinSync[PIN_TX_DATA] :
    (next_modCtrlEnable && pinSync[PIN_DUAL_MOD]);

  // ****************************************************************
  // output flops
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lockPin <= 1'b0;
      modCtrlEnable <= 1'b1;
      modFromTxData <= 1'b0;
      modCtrl <= 1'b0;
    end else begin
      lockPin <= next_lockPin;
      modCtrlEnable <= next_modCtrlEnable;
      modFromTxData <= next_modFromTxData;
      modCtrl <= next_modCtrl;
    end
  end
endmodule : tmc_lock_mux
`default_nettype wire

// file: tmc_main_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_main_control_regs #(
  parameter int REG_COUNT = 8,
  parameter int REG_WIDTH = 13,
  parameter int ADDR_WIDTH = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [ADDR_WIDTH-1:0] regAddr,
  input wire logic [REG_WIDTH-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [REG_WIDTH-1:0] regRdData,
  // asynchronous sources for the lock pin and modulation
  input wire logic pllLockIn,
  input wire logic vcoDividedIn,
  input wire logic refDividedIn,
  input wire logic prescalerIn,
  input wire logic shiftDataIn,
  input wire logic demodTestIn,
  input wire logic txDataIn,
  input wire logic dualModIn,
  // control fields from main and general registers two, three and five
  output logic chipPowerDown,
  output logic directionSelect,
  output logic [2:0] synthTestSel,
  output logic [4:0] ampGainCode,
  output logic [1:0] lowNoiseBiasStep,
  output logic [1:0] mixerBiasStep,
  output logic [1:0] oscDriveLevel,
  output logic demodTestHighBit,
  // general control words, register one in the low bits
  output logic [(REG_COUNT-1)*REG_WIDTH-1:0] generalCtrlFlat,
  // lock pin and modulation control
  output logic lockPin,
  output logic modCtrlEnable,
  output logic modFromTxData,
  output logic modCtrl
);
  import tmc_pkg::*;

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  // field positions are fixed at thirteen bits and eight words
  if (REG_WIDTH != tmc_pkg::REG_WIDTH || REG_COUNT != (1 << ADDR_WIDTH) ||
      REG_COUNT != tmc_pkg::REG_COUNT) begin : gBadShape
    $error("tmc_main_control_regs: unsupported register shape");
  end

  // ****************************************************************
  // register store
  // ****************************************************************
  logic [REG_COUNT*REG_WIDTH-1:0] wordsFlat;

  tmc_reg_store #(
    .REG_COUNT(REG_COUNT),
    .REG_WIDTH(REG_WIDTH),
    .ADDR_WIDTH(ADDR_WIDTH),
    .RESET_FLAT(RESET_FLAT)
  ) uStore (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(regWr),
    .wrAddr(regAddr),
    .wrData(regWrData),
    .rdEn(regRd),
    .rdAddr(regAddr),
    .rdData(regRdData),
    .wordsFlat(wordsFlat)
  );

  // ****************************************************************
  // field decode
  // ****************************************************************
  wire logic [12:0] mainCtrl = wordsFlat[ADDR_MAIN*REG_WIDTH +: REG_WIDTH];
  wire logic [12:0] genTwo = wordsFlat[ADDR_GEN_TWO*REG_WIDTH +: REG_WIDTH];
  wire logic [12:0] genThree = wordsFlat[ADDR_GEN_THREE*REG_WIDTH +: REG_WIDTH];
  wire logic [12:0] genFive = wordsFlat[ADDR_GEN_FIVE*REG_WIDTH +: REG_WIDTH];

  assign chipPowerDown = mainCtrl[MAIN_PD_BIT];
  assign directionSelect = mainCtrl[MAIN_DIR_BIT];
  assign synthTestSel = mainCtrl[MAIN_SEL_LO +: 3];
  assign ampGainCode = {genTwo[GEN_TWO_GAIN4_BIT], mainCtrl[MAIN_GAIN_LO +: 2],
    genThree[GEN_THREE_GAIN_LO +: 2]};
  assign lowNoiseBiasStep = mainCtrl[MAIN_LNA_LO +: 2];
  assign mixerBiasStep = mainCtrl[MAIN_MIX_LO +: 2];
  assign oscDriveLevel = mainCtrl[MAIN_OSC_LO +: 2];
  assign demodTestHighBit = genFive[GEN_FIVE_TDEM_HI_BIT];
  assign generalCtrlFlat = wordsFlat[REG_COUNT*REG_WIDTH-1:REG_WIDTH];

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // the analogue side runs on its own timing, so each source is caught twice
  wire logic [PIN_COUNT-1:0] pinRaw = {dualModIn, txDataIn, demodTestIn, shiftDataIn,
    prescalerIn, refDividedIn, vcoDividedIn, pllLockIn};
  logic [PIN_COUNT-1:0] pinMeta;
  logic [PIN_COUNT-1:0] pinSync;

  for (genvar p = 0; p < PIN_COUNT; p++) begin : gSync
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        pinMeta[p] <= 1'b0;
        pinSync[p] <= 1'b0;
      end else begin
        pinMeta[p] <= pinRaw[p];
        pinSync[p] <= pinMeta[p];
      end
    end
  end

  // ****************************************************************
  // lock pin and modulation
  // ****************************************************************
  // limitation: a source toggling faster than half of clk_sys is aliased
  tmc_lock_mux uLock (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .synthSel(synthTestSel),
    .demodHi(demodTestHighBit),
    .pinSync(pinSync),
    .lockPin(lockPin),
    .modCtrlEnable(modCtrlEnable),
    .modFromTxData(modFromTxData),
    .modCtrl(modCtrl)
  );

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cbSys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  wire logic selActive = !demodTestHighBit;

  a_main_write_lands: assert property (
    regWr && regAddr == ADDR_MAIN |=> mainCtrl == $past(regWrData))
    else $error("main control did not take the write");

  a_read_answer: assert property (
    regRd |=> regRdData == $past(wordsFlat[regAddr*REG_WIDTH +: REG_WIDTH]))
    else $error("read answer does not match the addressed word");

  a_idle_read_zero: assert property (
    !regRd |=> regRdData == '0)
    else $error("read data present outside the answer cycle");

  a_word_holds: assert property (
    !regWr |=> wordsFlat == $past(wordsFlat))
    else $error("register changed without a write");

  a_power_dir_map: assert property (
    regWr && regAddr == ADDR_MAIN |=>
      chipPowerDown == $past(regWrData[MAIN_PD_BIT]) &&
      directionSelect == $past(regWrData[MAIN_DIR_BIT]))
    else $error("power down or direction does not follow main control");

  a_direction_bit: assert property (
    regWr && regAddr != ADDR_MAIN |=>
      directionSelect == $past(directionSelect) && chipPowerDown == $past(chipPowerDown))
    else $error("direction or power down moved by a write elsewhere");

  a_reset_defaults: assert property (
    $rose(rst_b) |-> synthTestSel == SEL_NORMAL && lowNoiseBiasStep == BIAS_NOMINAL &&
      mixerBiasStep == BIAS_NOMINAL && oscDriveLevel == BIAS_NOMINAL)
    else $error("main control defaults wrong after reset");

  a_gain_assembly: assert property (
    regWr && regAddr == ADDR_GEN_THREE |=> ampGainCode[1:0] == $past(regWrData[12:11]))
    else $error("gain low bits not taken from general register three");

  a_gain_mid_bits: assert property (
    regWr |=>
      ($past(regAddr) != ADDR_MAIN ||
        ampGainCode[3:2] == $past(regWrData[MAIN_GAIN_LO +: 2])) &&
      ($past(regAddr) != ADDR_GEN_TWO ||
        ampGainCode[4] == $past(regWrData[GEN_TWO_GAIN4_BIT])))
    else $error("gain code assembled from the wrong bits");

  a_bias_fields: assert property (
    regWr && regAddr == ADDR_MAIN |=>
      {lowNoiseBiasStep, mixerBiasStep, oscDriveLevel} == $past(regWrData[MAIN_OSC_LO +: 6]))
    else $error("bias and drive fields misplaced");

  a_lock_vco: assert property (
    selActive && (synthTestSel == SEL_VCO_NOMOD || synthTestSel == SEL_VCO_MOD) |=>
      lockPin == $past(pinSync[PIN_VCO_DIV]) &&
      modCtrlEnable == ($past(synthTestSel) == SEL_VCO_MOD))
    else $error("divided oscillator routing or modulation wrong");

  a_lock_ref_presc: assert property (
    selActive && (synthTestSel == SEL_REF_DIV || synthTestSel == SEL_PRESCALER) |=>
      lockPin == (($past(synthTestSel) == SEL_REF_DIV) ? $past(pinSync[PIN_REF_DIV]) :
        $past(pinSync[PIN_PRESCALER])))
    else $error("reference divider or prescaler not on lock pin");

  a_txdata_mod: assert property (
    selActive && synthTestSel == SEL_TXDATA_MOD |=>
      modFromTxData && modCtrl == $past(pinSync[PIN_TX_DATA]) &&
      lockPin == $past(pinSync[PIN_VCO_DIV]))
    else $error("transmit data does not steer modulation");

  a_presc_nomod: assert property (
    selActive && synthTestSel == SEL_PRESC_NOMOD |=>
      !modCtrlEnable && !modCtrl && lockPin == $past(pinSync[PIN_PRESCALER]))
    else $error("prescaler test with modulation not held off");

  a_shift_data: assert property (
    selActive && synthTestSel == SEL_SHIFT_DATA |=> lockPin == $past(pinSync[PIN_SHIFT_DATA]))
    else $error("shift register data not on lock pin");

  a_demod_takeover: assert property (
    demodTestHighBit |=> lockPin == $past(pinSync[PIN_DEMOD_TEST]) && !modFromTxData)
    else $error("demodulator test output does not own the lock pin");

  a_normal_lock: assert property (
    selActive && synthTestSel == SEL_NORMAL |=>
      lockPin == $past(pinSync[PIN_PLL_LOCK]) && modCtrlEnable)
    else $error("normal mode does not show the lock indicator");

  cover_main_write: cover property (regWr && regAddr == ADDR_MAIN ##1 regRd);
  cover_txdata_mode: cover property (selActive && synthTestSel == SEL_TXDATA_MOD);
  cover_demod_mode: cover property (demodTestHighBit && synthTestSel != SEL_NORMAL);
  cover_back_to_back: cover property (regWr ##1 regRd ##1 regWr);
endmodule : tmc_main_control_regs
`default_nettype wire

// file: tmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmc_host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output logic [tmc_pkg::ADDR_WIDTH-1:0] regAddr,
  output logic [tmc_pkg::REG_WIDTH-1:0] regWrData,
  output logic regWr,
  output logic regRd,
  input wire logic [tmc_pkg::REG_WIDTH-1:0] regRdData
);
  import tmc_pkg::*;
  initial begin
    regAddr = 3'h0;
    regWrData = 13'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // ****************************************************************
  // bus cycles
  // ****************************************************************
  // released lines show the inverse, so a design that samples late sees junk
  task automatic write_reg(input logic [2:0] addr, input logic [12:0] data);
    @(posedge clk_sys);
    regAddr <= addr;
    regWrData <= data;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    regAddr <= ~addr;
    regWrData <= ~data;
  endtask : write_reg
  task automatic read_reg(input logic [2:0] addr, output logic [12:0] data);
    @(posedge clk_sys);
    regAddr <= addr;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    regAddr <= ~addr;
    // the answer stands for the one cycle after the strobe, taken at its closing edge
    @(posedge clk_sys);
    data = regRdData;
  endtask : read_reg
endmodule : tmc_host_model
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tmc_pkg::*;
  logic clk_sys;
  logic rst_b;
  logic [2:0] regAddr;
  logic [12:0] regWrData;
  logic regWr;
  logic regRd;
  logic [12:0] regRdData;
  logic [7:0] pins;
  logic chipPowerDown, directionSelect, demodTestHighBit;
  logic [2:0] synthTestSel;
  logic [4:0] ampGainCode;
  logic [1:0] lowNoiseBiasStep, mixerBiasStep, oscDriveLevel;
  logic [90:0] generalCtrlFlat;
  logic lockPin, modCtrlEnable, modFromTxData, modCtrl;
  int n_mismatch = 0;
  int checked = 0;

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  tmc_host_model i_host (.clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

  tmc_main_control_regs i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .pllLockIn(pins[PIN_PLL_LOCK]), .vcoDividedIn(pins[PIN_VCO_DIV]),
    .refDividedIn(pins[PIN_REF_DIV]), .prescalerIn(pins[PIN_PRESCALER]),
    .shiftDataIn(pins[PIN_SHIFT_DATA]), .demodTestIn(pins[PIN_DEMOD_TEST]),
    .txDataIn(pins[PIN_TX_DATA]), .dualModIn(pins[PIN_DUAL_MOD]),
    .chipPowerDown(chipPowerDown), .directionSelect(directionSelect),
    .synthTestSel(synthTestSel), .ampGainCode(ampGainCode),
    .lowNoiseBiasStep(lowNoiseBiasStep), .mixerBiasStep(mixerBiasStep),
    .oscDriveLevel(oscDriveLevel), .demodTestHighBit(demodTestHighBit),
    .generalCtrlFlat(generalCtrlFlat), .lockPin(lockPin), .modCtrlEnable(modCtrlEnable),
    .modFromTxData(modFromTxData), .modCtrl(modCtrl));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input string what, input logic [90:0] expv, input logic [90:0] got);
    checked++;
    if (got !== expv) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, expv, got);
    end
  endtask : check
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_cycles
  task automatic set_pins(input logic [7:0] v);
    @(posedge clk_sys);
    pins <= v;
    wait_cycles(5);
  endtask : set_pins
  function automatic logic [2:0] exp_src(input logic [2:0] s);
    case (s)
      3'h1, 3'h2, 3'h4: return PIN_VCO_DIV;
      3'h3: return PIN_REF_DIV;
      3'h5, 3'h6: return PIN_PRESCALER;
      3'h7: return PIN_SHIFT_DATA;
      default: return PIN_PLL_LOCK;
    endcase
  endfunction : exp_src

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_reset();
    logic [12:0] rd;
    for (int a = 0; a < 8; a++) begin
      i_host.read_reg(a[2:0], rd);
      check("reset word", (a == 0) ? 13'h002a : (a == 2) ? 13'h0040 : 13'h0000, rd);
    end
    check("reset sel", 3'h0, synthTestSel);
    check("reset bias", 6'h2a, {lowNoiseBiasStep, mixerBiasStep, oscDriveLevel});
  endtask : test_reset
  task automatic test_readback();
    logic [12:0] rd;
    for (int a = 0; a < 8; a++) i_host.write_reg(a[2:0], 13'h0a5a + a[12:0] * 13'h0203);
    for (int a = 0; a < 8; a++) begin
      i_host.read_reg(a[2:0], rd);
      check("readback", 13'h0a5a + a[12:0] * 13'h0203, rd);
      if (a > 0) check("general word", 13'h0a5a + a[12:0] * 13'h0203,
        generalCtrlFlat[(a-1)*13 +: 13]);
    end
  endtask : test_readback
  task automatic fields_case(input logic [12:0] m, input logic [12:0] g2, input logic [12:0] g3,
      input logic [4:0] amp);
    i_host.write_reg(3'h2, g2);
    i_host.write_reg(3'h3, g3);
    i_host.write_reg(3'h0, m);
    wait_cycles(1);
    check("power down", m[12], chipPowerDown);
    check("direction", m[11], directionSelect);
    check("gain code", amp, ampGainCode);
    check("low noise", m[5:4], lowNoiseBiasStep);
    check("mixer", m[3:2], mixerBiasStep);
    check("osc drive", m[1:0], oscDriveLevel);
  endtask : fields_case
  task automatic test_fields();
    fields_case(13'h189c, 13'h0100, 13'h0800, 5'b11001);
    fields_case(13'h0063, 13'h0000, 13'h1000, 5'b00110);
  endtask : test_fields
  task automatic test_lock_mux();
    logic [2:0] src;
    logic en;
    i_host.write_reg(3'h5, 13'h0000);
    for (int s = 0; s < 8; s++) begin
      src = exp_src(s[2:0]);
      en = !(s == 1 || s == 6);
      i_host.write_reg(3'h0, {2'b00, s[2:0], 8'h2a});
      set_pins((8'h1 << src) | (8'h1 << PIN_DUAL_MOD));
      check("sel field", s[2:0], synthTestSel);
      check("lock high", 1'b1, lockPin);
      check("mod enable", en, modCtrlEnable);
      check("mod tx", s == 4, modFromTxData);
      check("mod high", (s != 4) && en, modCtrl);
      set_pins(~((8'h1 << src) | (8'h1 << PIN_DUAL_MOD)));
      check("lock low", 1'b0, lockPin);
      check("mod low", s == 4, modCtrl);
    end
  endtask : test_lock_mux
  task automatic test_demod_override();
    i_host.write_reg(3'h5, 13'h0100);
    i_host.write_reg(3'h0, 13'h012a);
    set_pins(8'h1 << PIN_DEMOD_TEST);
    check("demod bit", 1'b1, demodTestHighBit);
    check("demod lock high", 1'b1, lockPin);
    check("demod mod enable", 1'b1, modCtrlEnable);
    set_pins(~(8'h1 << PIN_DEMOD_TEST));
    check("demod lock low", 1'b0, lockPin);
  endtask : test_demod_override

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  initial begin
    rst_b = 1'b0;
    pins = 8'h00;
    wait_cycles(2);
    rst_b <= 1'b1;
    test_reset();
    test_readback();
    test_fields();
    test_lock_mux();
    test_demod_override();
    conclude();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #(25 * 5000);
    n_mismatch++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
